//--- rtl/abc_address_break_unit.sv
// Function
// - two independent channels A and B, each with address and control, flag alone.
// - address bits 31 to 24 reserved, read undefined (zero here), writes ignored.
// - address bits 23 to 0 hold the read/write break address, reset zero.
// - control bit 7 is the match flag, set by hardware on a match, reset 0.
// - flag clears only by reading it as 1 then writing 0.
// - control bit 6: 0 qualifies processor cycles, 1 processor and transfer controller.
// - mask codes 000 to 100 ignore zero to four low address bits.
// - mask codes 101, 110, 111 ignore the low 8, 12, 16 address bits.
// - bits 2 to 1 pick fetch, data read, data write, or read or write.
// - control bit 0 gates the break request, reset 0.
// - fetch break is requested before the fetched instruction executes.
// - data break is requested right after the accessing instruction finishes.
// - channel B has the same layout, resets and behaviour as channel A.
// - an external module stop control halts the unit.
// - a flag left set keeps the break request asserted while enabled.
// - both channels share one break request line.
// - unit starts halted after reset; registers reachable only after stop release.
`timescale 1ns/100ps
module abc_address_break_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic module_stop,
	input wire abc_pkg::abc_bus_s bus,
	input wire logic insn_end,
	output logic break_req,
	output logic irq
);

	abc_pkg::abc_state_s q;
	abc_pkg::abc_state_s d;
	logic [1:0] hit_fetch;
	logic [1:0] hit_data;

	// care bits of the address compare for a mask code
	function automatic logic [23:0] abc_care(input logic [2:0] code);
		logic [23:0] c;
		c = 24'hffffff;
		case (code)
			3'h0: c = 24'hffffff;
			3'h1: c = 24'hfffffe;
			3'h2: c = 24'hfffffc;
			3'h3: c = 24'hfffff8;
			3'h4: c = 24'hfffff0;
			3'h5: c = 24'hffff00;
			3'h6: c = 24'hfff000;
			3'h7: c = 24'hff0000;
			default: c = 24'hffffff;
		endcase
		return c;
	endfunction

	// does the watched cycle type satisfy a condition code
	function automatic logic abc_cond_ok(input logic [1:0] cond, input abc_pkg::abc_kind_e kind);
		logic ok;
		ok = 1'b0;
		case (cond)
			abc_pkg::COND_FETCH: ok = (kind == abc_pkg::KIND_FETCH);
			abc_pkg::COND_READ: ok = (kind == abc_pkg::KIND_READ);
			abc_pkg::COND_WRITE: ok = (kind == abc_pkg::KIND_WRITE);
			abc_pkg::COND_RW: ok = (kind == abc_pkg::KIND_READ) || (kind == abc_pkg::KIND_WRITE);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic [31:0] abc_ctl_word(input abc_pkg::abc_bcr_s c);
		return {24'h000000, c};
	endfunction

	for (genvar g = 0; g < 2; g++) begin : g_ch
		logic addr_eq;
		logic qual;
		logic match;
		assign addr_eq = ((bus.addr ^ q.brk_addr[g]) & abc_care(q.ctl[g].mask_sel)) == 24'h000000;
		assign qual = !bus.transfer_controller || q.ctl[g].qualify;
		assign match = bus.valid && addr_eq && qual && abc_cond_ok(q.ctl[g].cond, bus.kind);
		assign hit_fetch[g] = match && (bus.kind == abc_pkg::KIND_FETCH);
		assign hit_data[g] = match && (bus.kind != abc_pkg::KIND_FETCH);
	end

	logic setup;
	logic access;
	logic mapped;
	logic [1:0] set_now;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign mapped = (paddr == abc_pkg::OFF_BREAK_ADDRESS_A) || (paddr == abc_pkg::OFF_BREAK_ADDRESS_B)
		|| (paddr == abc_pkg::OFF_BREAK_CONTROL_A) || (paddr == abc_pkg::OFF_BREAK_CONTROL_B)
		|| (paddr == abc_pkg::OFF_IRQ_STATUS) || (paddr == abc_pkg::OFF_IRQ_MASK);

	always_comb begin
		d = q;
		d.stop = module_stop;
		for (int i = 0; i < 2; i++) begin
			// fetch break flagged at the fetch, ahead of execution
			// data break held until the instruction ends
			set_now[i] = !q.stop && (hit_fetch[i] || ((q.pend[i] || hit_data[i]) && insn_end));
			d.pend[i] = !q.stop && (q.pend[i] || hit_data[i]) && !insn_end;
		end
		// read data captured in the setup cycle so prdata leaves a flop
		if (setup) begin
			d.rdata = 32'h00000000;
			case (paddr)
				abc_pkg::OFF_BREAK_ADDRESS_A: d.rdata = {8'h00, q.brk_addr[0]};
				abc_pkg::OFF_BREAK_ADDRESS_B: d.rdata = {8'h00, q.brk_addr[1]};
				abc_pkg::OFF_BREAK_CONTROL_A: d.rdata = abc_ctl_word(q.ctl[0]);
				abc_pkg::OFF_BREAK_CONTROL_B: d.rdata = abc_ctl_word(q.ctl[1]);
				abc_pkg::OFF_IRQ_STATUS: d.rdata = {30'h00000000, q.stat};
				abc_pkg::OFF_IRQ_MASK: d.rdata = {30'h00000000, q.mask};
				default: d.rdata = 32'h00000000;
			endcase
		end
		if (access && !q.stop && mapped) begin
			if (pwrite) begin
				case (paddr)
					// break address write, upper byte kept out
					abc_pkg::OFF_BREAK_ADDRESS_A: d.brk_addr[0] = pwdata[23:0];
					abc_pkg::OFF_BREAK_ADDRESS_B: d.brk_addr[1] = pwdata[23:0];
					abc_pkg::OFF_BREAK_CONTROL_A,
					abc_pkg::OFF_BREAK_CONTROL_B: begin
						d.ctl[paddr[2]].qualify = pwdata[abc_pkg::BCR_QUAL_POS];
						d.ctl[paddr[2]].mask_sel = pwdata[abc_pkg::BCR_MASK_LSB +: 3];
						d.ctl[paddr[2]].cond = pwdata[abc_pkg::BCR_COND_LSB +: 2];
						d.ctl[paddr[2]].irq_en = pwdata[abc_pkg::BCR_IE_POS];
						// clear only after a read saw it set; writing 1 keeps it
						if (q.armed[paddr[2]] && !pwdata[abc_pkg::BCR_FLAG_POS]) begin
							d.ctl[paddr[2]].flag = 1'b0;
						end
						d.armed[paddr[2]] = 1'b0;
					end
					abc_pkg::OFF_IRQ_MASK: d.mask = pwdata[1:0];
					default: d.mask = q.mask;
				endcase
			end else begin
				// read of a set flag arms the clear
				if (paddr == abc_pkg::OFF_BREAK_CONTROL_A && q.ctl[0].flag) begin
					d.armed[0] = 1'b1;
				end
				if (paddr == abc_pkg::OFF_BREAK_CONTROL_B && q.ctl[1].flag) begin
					d.armed[1] = 1'b1;
				end
				if (paddr == abc_pkg::OFF_IRQ_STATUS) begin
					d.stat = 2'h0;
				end
			end
		end
		// a match in the clearing cycle wins
		for (int i = 0; i < 2; i++) begin
			if (set_now[i]) begin
				d.ctl[i].flag = 1'b1;
				d.stat[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.brk_addr <= {abc_pkg::RST_BREAK_ADDR, abc_pkg::RST_BREAK_ADDR};
			q.ctl <= {abc_pkg::RST_BREAK_CTRL, abc_pkg::RST_BREAK_CTRL};
			q.armed <= 2'h0;
			q.pend <= 2'h0;
			q.stat <= 2'h0;
			q.mask <= abc_pkg::RST_IRQ_MASK;
			q.stop <= abc_pkg::RST_MODULE_STOP;
			q.rdata <= 32'h00000000;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.rdata;
	assign pready = 1'b1;
	assign pslverr = access && (q.stop || !mapped);

	assign break_req = !q.stop && ((q.ctl[0].flag && q.ctl[0].irq_en)
		|| (q.ctl[1].flag && q.ctl[1].irq_en));
	assign irq = |(q.stat & q.mask);

endmodule

//--- rtl/abc_pkg.sv
package abc_pkg;

	localparam int unsigned ADDR_W = 24;
	localparam int unsigned NCH = 2;

	// register offsets (byte addresses, one word each)
	localparam logic [7:0] OFF_BREAK_ADDRESS_A = 8'h00;
	localparam logic [7:0] OFF_BREAK_ADDRESS_B = 8'h04;
	localparam logic [7:0] OFF_BREAK_CONTROL_A = 8'h08;
	localparam logic [7:0] OFF_BREAK_CONTROL_B = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

	// break control field positions
	localparam int unsigned BCR_FLAG_POS = 7;
	localparam int unsigned BCR_QUAL_POS = 6;
	localparam int unsigned BCR_MASK_LSB = 3;
	localparam int unsigned BCR_COND_LSB = 1;
	localparam int unsigned BCR_IE_POS = 0;

	// reset values
	localparam logic [23:0] RST_BREAK_ADDR = 24'h000000;
	localparam logic [7:0] RST_BREAK_CTRL = 8'h00;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;
	localparam logic RST_MODULE_STOP = 1'b1;

	// cycle type condition codes
	localparam logic [1:0] COND_FETCH = 2'h0;
	localparam logic [1:0] COND_READ = 2'h1;
	localparam logic [1:0] COND_WRITE = 2'h2;
	localparam logic [1:0] COND_RW = 2'h3;

	typedef enum logic [2:0] {
		KIND_FETCH = 3'b001,
		KIND_READ = 3'b010,
		KIND_WRITE = 3'b100
	} abc_kind_e;

	// one cycle of the watched internal bus
	typedef struct packed {
		logic valid;
		abc_kind_e kind;
		logic transfer_controller;
		logic [23:0] addr;
	} abc_bus_s;

	typedef struct packed {
		logic flag;
		logic qualify;
		logic [2:0] mask_sel;
		logic [1:0] cond;
		logic irq_en;
	} abc_bcr_s;

	typedef struct packed {
		logic [1:0][23:0] brk_addr;
		abc_bcr_s [1:0] ctl;
		logic [1:0] armed;
		logic [1:0] pend;
		logic [1:0] stat;
		logic [1:0] mask;
		logic stop;
		logic [31:0] rdata;
	} abc_state_s;

endpackage

//--- tb/abc_core_model.sv
`timescale 1ns/100ps
module abc_core_model (
	input wire logic pclk,
	output abc_pkg::abc_bus_s bus,
	output logic insn_end
);
	initial begin
		bus = '0;
		insn_end = 1'b0;
	end
	// idle bus shows the inverted address so a stale match is not possible
	task cyc(input logic [2:0] k, input logic t, input logic [23:0] a, input logic e);
		@(posedge pclk);
		bus <= {1'b1, k, t, a};
		insn_end <= e;
		@(posedge pclk);
		bus <= {1'b0, k, t, ~a};
		insn_end <= 1'b0;
	endtask
	// instruction end on its own, for a data access that finishes later
	task fin;
		@(posedge pclk);
		insn_end <= 1'b1;
		@(posedge pclk);
		insn_end <= 1'b0;
	endtask
endmodule

//--- tb/abc_break_properties.sv
`timescale 1ns/100ps
module abc_break_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic module_stop,
	input wire abc_pkg::abc_bus_s bus,
	input wire logic insn_end,
	input wire logic break_req,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_now: assert property (psel && penable |-> pready)
		else $error("no ready");
	chk_bad_addr: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
		else $error("unmapped ok");
	chk_err_phase: assert property (pslverr |-> psel && penable)
		else $error("stray error");
	chk_halt_err: assert property (psel && penable && $past(module_stop) |-> pslverr)
		else $error("halted access ok");
	chk_halt_quiet: assert property (module_stop |=> !break_req)
		else $error("request while halted");
	chk_req_cause: assert property ($rose(break_req) |-> $past(bus.valid) || $past(insn_end)
		|| $past(psel && penable && pwrite) || $past(module_stop, 2))
		else $error("request without cause");
	chk_req_drop: assert property ($fell(break_req) |-> $past(psel && penable && pwrite)
		|| $past(module_stop))
		else $error("request dropped alone");
	chk_irq_drop: assert property ($fell(irq) |-> $past(psel && penable))
		else $error("irq dropped alone");
	cover property ($rose(break_req));
	cover property ($rose(irq));
	cover property (pslverr);
endmodule
bind abc_address_break_unit abc_break_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .module_stop(module_stop),
	.bus(bus), .insn_end(insn_end), .break_req(break_req), .irq(irq));

//--- tb/abc_address_break_unit_tb.sv
`timescale 1ns/100ps
module abc_address_break_unit_tb;
	logic pclk, presetn, psel, penable, pwrite, module_stop, pready, pslverr, insn_end;
	logic break_req, irq, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	abc_pkg::abc_bus_s bus;
	int bad_count, checks;
	int mb[8] = '{0, 1, 2, 3, 4, 8, 12, 16};
	abc_address_break_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .module_stop(module_stop),
		.bus(bus), .insn_end(insn_end), .break_req(break_req), .irq(irq));
	abc_core_model m (.pclk(pclk), .bus(bus), .insn_end(insn_end));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task finish_test;
		$display("mismatches %0d checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		if (n >= 20) begin
			bad_count++;
			finish_test;
		end
	endtask
	// flag is read, compared, then cleared by writing the setting back with bit 7 low
	task go(input int ch, input logic [7:0] c, input logic [2:0] k, input logic t,
		input logic [23:0] a, input logic x);
		logic [7:0] o;
		o = abc_pkg::OFF_BREAK_CONTROL_A + 8'(ch * 4);
		apb(1'b1, o, {24'h0, c});
		m.cyc(k, t, a, 1'b1);
		#1 chk(break_req, 1'b0);
		apb(1'b0, o, 32'h0);
		chk(r[7], x);
		apb(1'b1, o, {24'h0, c});
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, module_stop} = 1'b1;
		bad_count = 0;
		checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 8'h00, 32'h123);
		chk(e, 1'b1);
		module_stop <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk(e, 1'b1);
		apb(1'b1, 8'h04, 32'hff5a5a5a);
		apb(1'b0, 8'h04, 32'h0);
		chk(r, 32'h005a5a5a);
		for (int k = 0; k < 8; k++) begin
			go(1, {2'b0, 3'(k), 3'b010}, 3'b010, 1'b0, 24'h5a5a5a ^ 24'((1 << mb[k]) - 1), 1'b1);
			go(1, {2'b0, 3'(k), 3'b010}, 3'b010, 1'b0, 24'h5a5a5a ^ 24'(1 << mb[k]), 1'b0);
		end
		for (int c = 0; c < 4; c++)
			for (int k = 0; k < 3; k++)
				go(0, {5'b0, 2'(c), 1'b0}, 3'(1 << k), 1'b0, 24'h0,
					c == 0 ? k == 0 : c == 3 ? k != 0 : c == k);
		go(0, 8'h02, 3'b010, 1'b1, 24'h0, 1'b0);
		go(0, 8'h42, 3'b010, 1'b1, 24'h0, 1'b1);
		// data break waits for the end of the accessing instruction
		apb(1'b1, 8'h0c, 32'h03);
		m.cyc(3'b010, 1'b0, 24'h5a5a5a, 1'b0);
		repeat (2) @(posedge pclk);
		#1 chk(break_req, 1'b0);
		m.fin;
		#1 chk(break_req, 1'b1);
		apb(1'b0, 8'h0c, 32'h0);
		apb(1'b1, 8'h0c, 32'h00);
		#1 chk(break_req, 1'b0);
		apb(1'b1, 8'h14, 32'h1);
		apb(1'b1, 8'h08, 32'h01);
		m.cyc(3'b001, 1'b0, 24'h0, 1'b1);
		#1 chk({break_req, irq}, 2'b11);
		apb(1'b0, 8'h10, 32'h0);
		#1 chk({r[1:0], irq}, 3'b110);
		// a clearing write without a prior read must leave the flag set
		apb(1'b1, 8'h08, 32'h01);
		apb(1'b0, 8'h08, 32'h0);
		#1 chk({r, break_req}, 33'h103);
		apb(1'b1, 8'h08, 32'h01);
		#1 chk(break_req, 1'b0);
		module_stop <= 1'b1;
		repeat (2) @(posedge pclk);
		m.cyc(3'b001, 1'b0, 24'h0, 1'b1);
		module_stop <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		chk(r, 32'h01);
		finish_test;
	end
endmodule
